// File: design/spixf_core.sv
`timescale 1ns/1ps
// Functional notes
// - slave drives miso only while selected
// - phase 0: msb on miso at select
// - no shift reload during slave transfer
// - phase 1: first clock edge starts slave
// - master write starts; phase 0 idle half
// - phase 1 master: first edge idle-to-active
// - master bit clock runs only when enabled
// - master start within one bit time
// - overflow at bit 1 capture, blocks receive
// - status then data read clears overflow
// - errors raise combined receive/error request
// - pin directions follow master select
// - mode fault: slave deselect mid transfer, master select
// - fault flag set only when enabled
// - master fault disables and releases pins
// - slave transfer span per phase
// - fault keeps master select bit
// - phase 0 deselect faults without clocks
// - slave fault leaves enable alone
// - deselected slave ignores clocks, tristates miso
// - status read then ctrl write clears fault
// - rx full clear; data write clears empty
// - disabled: abort, empty set, pins released
module spixf_core
  import spixf_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // serial pins, inputs from outside
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  // serial pin drives
  output spixf_pins_t pins_o,
  // combined receive/error request
  output logic rx_err_irq_o
);

  // ============================================================
  // state
  // ============================================================
  typedef struct packed {
    logic [1:0] ss_sy;      // select synchroniser
    logic [1:0] sck_sy;     // clock synchroniser
    logic [1:0] mosi_sy;    // mosi synchroniser
    logic [1:0] miso_sy;    // miso synchroniser
    logic sck_prev;         // last synced clock
    logic ss_prev;          // last synced select
    logic rx_ie;            // ctrl bits
    logic master;
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic enable;
    logic tx_ie;
    logic error_irq_enable;            // status_ctrl bits
    logic mode_fault_enable;
    logic [1:0] rate;
    logic rxf;              // flags
    logic ovr;
    logic mode_fault_flag;
    logic txe;
    logic arm_rx;           // status read seen rxf/ovr
    logic arm_mode_fault_flag;         // status read seen mode_fault_flag
    logic [7:0] tx_buf;     // transmit buffer
    logic [7:0] rx_buf;     // receive register
    logic [7:0] shift;      // outgoing shift register
    logic [7:0] rxs;        // incoming shift register
    logic busy;             // transfer in progress
    logic pend;             // master byte waiting for tick
    logic [3:0] half;       // master half bit index
    logic [3:0] cnt;        // captured bits
    logic [1:0] cap_d;      // master capture, delayed for pin and sync lag
    logic [1:0] fin_d;      // master end of byte, delayed alongside
    logic [6:0] div;        // master bit clock divider
    spixf_pins_t pins;      // pin drives
    logic irq;
    logic ack;
    logic [31:0] dat;
  } spixf_state_t;

  spixf_state_t s;
  spixf_state_t n;

  // bus decode
  logic take;
  logic wr_ctrl;
  logic rd_stat;
  logic wr_stat;
  logic rd_data;
  logic wr_data;
  // link events
  logic sck_now;
  logic sel;
  logic lead;
  logic trail;
  logic ss_rise;
  logic ss_fall;
  logic tick;
  logic fault_m;
  logic fault_s;
  logic fault_cond;
  logic samp;
  logic shft;
  logic done;
  logic [6:0] half_m1;
  logic [7:0] stat_rd;
  logic [7:0] ctrl_rd;

  // ============================================================
  // bus decode and events
  // ============================================================
  // request taken in its first cycle, answered one cycle later
  always_comb begin
    take = cyc_i && stb_i && !s.ack;
    wr_ctrl = take && we_i && sel_i[0] && adr_i == SPIXF_OFF_CTRL;
    rd_stat = take && !we_i && adr_i == SPIXF_OFF_STAT;
    wr_stat = take && we_i && sel_i[0] && adr_i == SPIXF_OFF_STAT;
    rd_data = take && !we_i && adr_i == SPIXF_OFF_DATA;
    wr_data = take && we_i && sel_i[0] && adr_i == SPIXF_OFF_DATA;
    sck_now = s.sck_sy[1];
    sel = !s.ss_sy[1];
    lead = (sck_now != s.clock_polarity_sel) && (s.sck_prev == s.clock_polarity_sel);
    trail = (sck_now == s.clock_polarity_sel) && (s.sck_prev != s.clock_polarity_sel);
    ss_rise = s.ss_sy[1] && !s.ss_prev;
    ss_fall = !s.ss_sy[1] && s.ss_prev;
    case (s.rate)
      2'b00: half_m1 = SPIXF_HALF_DIV2;
      2'b01: half_m1 = SPIXF_HALF_DIV8;
      2'b10: half_m1 = SPIXF_HALF_DIV32;
      default: half_m1 = SPIXF_HALF_DIV128;
    endcase
    // free-running tick, only when enabled master
    tick = s.enable && s.master && s.div == 7'h00;
    // fault on master selected, or slave lost mid transfer
    fault_cond = s.enable && s.master && sel;
    fault_m = fault_cond;
    fault_s = s.enable && !s.master && ss_rise && s.busy;
    ctrl_rd = '0;
    ctrl_rd[SPIXF_C_RXIE] = s.rx_ie;
    ctrl_rd[SPIXF_C_MASTER_SELECT_ALIAS] = s.master;
    ctrl_rd[SPIXF_C_CLOCK_POLARITY_SEL] = s.clock_polarity_sel;
    ctrl_rd[SPIXF_C_CLOCK_PHASE_SEL] = s.clock_phase_sel;
    ctrl_rd[SPIXF_C_EN] = s.enable;
    ctrl_rd[SPIXF_C_TXIE] = s.tx_ie;
    stat_rd = '0;
    stat_rd[SPIXF_S_RXF] = s.rxf;
    stat_rd[SPIXF_S_ERROR_IRQ_ENABLE] = s.error_irq_enable;
    stat_rd[SPIXF_S_OVR] = s.ovr;
    stat_rd[SPIXF_S_MODE_FAULT_FLAG] = s.mode_fault_flag;
    stat_rd[SPIXF_S_TXE] = s.txe;
    stat_rd[SPIXF_S_MODE_FAULT_ENABLE] = s.mode_fault_enable;
    stat_rd[SPIXF_S_RATE +: 2] = s.rate;
  end

  // ============================================================
  // next state
  // ============================================================
  always_comb begin
    n = s;
    samp = 1'b0;
    shft = 1'b0;
    done = 1'b0;
    // synchronisers: first stage read only by the second
    n.ss_sy = {s.ss_sy[0], ss_n_i};
    n.sck_sy = {s.sck_sy[0], sck_i};
    n.mosi_sy = {s.mosi_sy[0], mosi_i};
    n.miso_sy = {s.miso_sy[0], miso_i};
    n.sck_prev = sck_now;
    n.ss_prev = s.ss_sy[1];
    // bus answer, dropped the cycle after it was given
    n.ack = take;
    n.dat = '0;
    if (take && !we_i) begin
      case (adr_i)
        SPIXF_OFF_CTRL: n.dat = {24'h000000, ctrl_rd};
        SPIXF_OFF_STAT: n.dat = {24'h000000, stat_rd};
        SPIXF_OFF_DATA: n.dat = {24'h000000, s.rx_buf};
        default: n.dat = '0;
      endcase
    end
    // register writes; clears come first so a set below wins
    if (wr_ctrl) begin
      n.rx_ie = dat_i[SPIXF_C_RXIE];
      n.master = dat_i[SPIXF_C_MASTER_SELECT_ALIAS];
      n.clock_polarity_sel = dat_i[SPIXF_C_CLOCK_POLARITY_SEL];
      n.clock_phase_sel = dat_i[SPIXF_C_CLOCK_PHASE_SEL];
      n.enable = dat_i[SPIXF_C_EN];
      n.tx_ie = dat_i[SPIXF_C_TXIE];
      // clear only after armed read, never while fault persists
      if (s.arm_mode_fault_flag && !fault_cond) begin
        n.mode_fault_flag = 1'b0;
        n.arm_mode_fault_flag = 1'b0;
      end
    end
    if (wr_stat) begin
      n.error_irq_enable = dat_i[SPIXF_S_ERROR_IRQ_ENABLE];
      n.mode_fault_enable = dat_i[SPIXF_S_MODE_FAULT_ENABLE];
      n.rate = dat_i[SPIXF_S_RATE +: 2];
    end
    if (rd_stat) begin
      n.arm_rx = s.rxf || s.ovr;
      n.arm_mode_fault_flag = s.mode_fault_flag;
    end
    // armed data read clears receive flags, data kept
    if (rd_data && s.arm_rx) begin
      n.rxf = 1'b0;
      n.ovr = 1'b0;
      n.arm_rx = 1'b0;
    end
    // data write fills the buffer, empties no more
    if (wr_data) begin
      n.tx_buf = dat_i[7:0];
      n.txe = 1'b0;
    end
    // divider reloads each half bit, held while not master
    if (!(s.enable && s.master)) begin
      n.div = 7'h00;
    end else if (tick) begin
      n.div = half_m1;
    end else begin
      n.div = s.div - 7'h01;
    end
    if (s.enable && !s.busy && !s.pend && !s.txe) begin
      n.shift = s.tx_buf;
      // a write landing in the same cycle keeps the buffer full
      n.txe = !wr_data;
      n.pend = s.master;
    end
    // master round trip: sck out flop, far side, two sync flops
    n.cap_d = {s.cap_d[0], 1'b0};
    n.fin_d = {s.fin_d[0], 1'b0};
    if (s.enable && s.master) begin
      // start on the next tick, at most one half bit away
      if (tick && s.pend && !s.busy) begin
        n.busy = 1'b1;
        n.pend = 1'b0;
        n.half = 4'h0;
        n.cnt = 4'h0;
      end else if (tick && s.busy) begin
        // capture at end of even halves, shift at end of odd ones but the last
        // capture and end are taken two cycles late, after the echo settles
        n.cap_d[0] = !s.half[0];
        n.fin_d[0] = s.half == SPIXF_LAST_HALF;
        shft = s.half[0] && s.half != SPIXF_LAST_HALF;
        if (s.half == SPIXF_LAST_HALF) begin
          n.busy = 1'b0;
        end
        n.half = s.half + 4'h1;
      end
      samp = s.cap_d[1];
      done = s.fin_d[1];
    end else if (s.enable) begin
      // deselect stops the transfer and ignores clocks
      if (!sel) begin
        n.busy = 1'b0;
      end else if (!s.clock_phase_sel) begin
        // select fall starts, msb already on miso
        if (ss_fall) begin
          n.busy = 1'b1;
          n.cnt = 4'h0;
        end else if (s.busy && lead) begin
          samp = 1'b1;
        end else if (s.busy && trail) begin
          shft = s.cnt != SPIXF_BITS;
          done = s.cnt == SPIXF_BITS;
        end
      end else begin
        // first edge from idle starts phase 1 transfer
        if (!s.busy && lead) begin
          n.busy = 1'b1;
          n.cnt = 4'h0;
        end else if (s.busy && lead) begin
          shft = 1'b1;
        end else if (s.busy && trail) begin
          samp = 1'b1;
          done = s.cnt == SPIXF_BITS - 4'h1;
        end
      end
    end
    // msb first, one bit per capture
    if (shft) begin
      n.shift = {s.shift[6:0], 1'b0};
    end
    if (samp) begin
      n.rxs = {s.rxs[6:0], s.master ? s.miso_sy[1] : s.mosi_sy[1]};
      n.cnt = s.cnt + 4'h1;
      // unread byte when bit 1 is captured
      if (s.cnt == SPIXF_OVR_CAPT && s.rxf) begin
        n.ovr = 1'b1;
      end
    end
    if (done) begin
      // master busy already dropped; a new byte may have started
      if (!s.master) begin
        n.busy = 1'b0;
      end
      // while overflow stands nothing enters the receive register
      if (!n.ovr) begin
        n.rx_buf = n.rxs;
        n.rxf = 1'b1;
      end
    end
    // fault flag needs its enable; master bit untouched
    if (s.mode_fault_enable && (fault_m || fault_s)) begin
      n.mode_fault_flag = 1'b1;
      // master fault disables; slave fault does not
      n.enable = n.enable && !fault_m;
    end
    // disabled: abort, clear counters, empty set
    if (!n.enable) begin
      n.txe = 1'b1;
      n.busy = 1'b0;
      n.pend = 1'b0;
      n.shift = 8'h00;
      n.half = 4'h0;
      n.cnt = 4'h0;
      n.cap_d = 2'b00;
      n.fin_d = 2'b00;
    end
    n.pins.sck_oe = n.enable && n.master;
    n.pins.mosi_oe = n.enable && n.master;
    // miso driven only by a selected slave
    n.pins.miso_oe = n.enable && !n.master && !s.ss_sy[1];
    n.pins.mosi = n.shift[7];
    n.pins.miso = n.shift[7];
    // phase 0 active in odd halves, phase 1 in even ones
    n.pins.sck = n.clock_polarity_sel ^ (n.busy && (n.half[0] ^ n.clock_phase_sel));
    // errors and receive full share one request
    n.irq = (n.error_irq_enable && (n.mode_fault_flag || n.ovr)) || (n.rx_ie && n.rxf);
  end

  // ============================================================
  // registers
  // ============================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.ss_sy <= 2'b11;
      s.ss_prev <= 1'b1;
      s.master <= SPIXF_RST_MASTER_SELECT_ALIAS;
      s.clock_phase_sel <= SPIXF_RST_CLOCK_PHASE_SEL;
      s.txe <= SPIXF_RST_TXE;
    end else begin
      s <= n;
    end
  end

  // outputs straight from flops
  always_comb begin
    dat_o = s.dat;
    ack_o = s.ack;
    pins_o = s.pins;
    rx_err_irq_o = s.irq;
  end

  // ============================================================
  // assertions
  // ============================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_pend_rise;
    $rose(s.pend) && s.master;
  endsequence
  sequence seq_started;
    ##[1:130] (!s.pend);
  endsequence

  AST_MISO_HIZ: assert property (s.ss_sy[1] |=> !s.pins.miso_oe)
    else $error("miso driven while deselected");
  AST_TX_EMPTY_CLR: assert property ((wr_data && s.enable && !fault_m) |=> !s.txe)
    else $error("data write left empty flag set");
  AST_DIS_ABORT: assert property (!s.enable |-> s.txe && !s.busy && !s.pins.sck_oe)
    else $error("disabled block still active");
  AST_MFAULT_SIDE: assert property ((fault_m && s.mode_fault_enable) |=>
    !s.enable && s.txe && s.mode_fault_flag && $stable(s.master))
    else $error("master fault side effects missing");
  AST_MODE_FAULT_FLAG_GATED: assert property ($rose(s.mode_fault_flag) |-> $past(s.mode_fault_enable))
    else $error("fault flag set while disabled");
  AST_START_LAT: assert property (seq_pend_rise |-> seq_started)
    else $error("master start too late");
  AST_OVR_HOLD: assert property (s.ovr |=> $stable(s.rx_buf))
    else $error("receive register changed under overflow");
  AST_SCK_IDLE: assert property (($rose(s.busy) && s.master && !s.clock_phase_sel) |->
    s.pins.sck == s.clock_polarity_sel [*1] ##1 1'b1)
    else $error("phase 0 clock not idle at start");

endmodule

// File: design/spixf_pkg.sv
// ============================================================
// shared constants and carriers of the spi transfer engine
// ============================================================
package spixf_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] SPIXF_OFF_CTRL = 4'h0;
  localparam logic [3:0] SPIXF_OFF_STAT = 4'h4;
  localparam logic [3:0] SPIXF_OFF_DATA = 4'h8;

  // ctrl_reg field positions
  localparam int SPIXF_C_RXIE = 7;
  localparam int SPIXF_C_MASTER_SELECT_ALIAS = 5;
  localparam int SPIXF_C_CLOCK_POLARITY_SEL = 4;
  localparam int SPIXF_C_CLOCK_PHASE_SEL = 3;
  localparam int SPIXF_C_EN = 1;
  localparam int SPIXF_C_TXIE = 0;

  // status_ctrl_reg field positions
  localparam int SPIXF_S_RXF = 7;
  localparam int SPIXF_S_ERROR_IRQ_ENABLE = 6;
  localparam int SPIXF_S_OVR = 5;
  localparam int SPIXF_S_MODE_FAULT_FLAG = 4;
  localparam int SPIXF_S_TXE = 3;
  localparam int SPIXF_S_MODE_FAULT_ENABLE = 2;
  localparam int SPIXF_S_RATE = 0;

  // values after reset: master on, phase 1, transmit empty
  localparam logic SPIXF_RST_MASTER_SELECT_ALIAS = 1'b1;
  localparam logic SPIXF_RST_CLOCK_PHASE_SEL = 1'b1;
  localparam logic SPIXF_RST_TXE = 1'b1;

  // half bit time minus one, in bus cycles, per rate code
  localparam logic [6:0] SPIXF_HALF_DIV2 = 7'h00;
  localparam logic [6:0] SPIXF_HALF_DIV8 = 7'h03;
  localparam logic [6:0] SPIXF_HALF_DIV32 = 7'h0F;
  localparam logic [6:0] SPIXF_HALF_DIV128 = 7'h3F;

  // bits per transfer, last half index, overflow capture index
  localparam logic [3:0] SPIXF_BITS = 4'h8;
  localparam logic [3:0] SPIXF_LAST_HALF = 4'hF;
  localparam logic [3:0] SPIXF_OVR_CAPT = 4'h6;

  // pin drive carrier: level and enable per pin
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } spixf_pins_t;

endpackage

// File: dv/spixf_peer.sv
`timescale 1ns/1ps
// ============================================================
// far-side spi slave, behavioural
// ============================================================
module spixf_peer (
  // serial side
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic ss_n_i,
  output logic miso_o,
  // format and data
  input wire logic clock_polarity_sel_i,
  input wire logic clock_phase_sel_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [7:0] sh; // byte being sent
  int n; // index of the bit on miso
  logic bit_q; // last driven bit
  wire act = sck_i ^ clock_polarity_sel_i; // high while the clock is active
  // released line shows the inverse, so a stale bit never passes
  assign miso_o = ss_n_i ? ~bit_q : bit_q;
  // select loads the byte; phase 0 puts the msb out at once
  always @(negedge ss_n_i) begin
    sh = tx_i;
    n = 7;
    bit_q = clock_phase_sel_i ? ~tx_i[7] : tx_i[7];
  end
  // leading edge: phase 1 drives, phase 0 samples
  always @(posedge act) begin
    if (!ss_n_i) begin
      if (clock_phase_sel_i) bit_q = sh[n];
      else rx_o = {rx_o[6:0], mosi_i};
    end
  end
  // trailing edge: phase 1 samples, phase 0 drives the next bit
  always @(negedge act) begin
    if (!ss_n_i) begin
      if (clock_phase_sel_i) rx_o = {rx_o[6:0], mosi_i};
      if (n > 0) begin
        n--;
        if (!clock_phase_sel_i) bit_q = sh[n];
      end
    end
  end
endmodule

// File: dv/spixf_tb_top.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench of the spi transfer engine
// ============================================================
module spixf_tb_top;
  import spixf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic dut_ss_n = 1'b1; // select seen by the design
  logic peer_ss_n = 1'b1; // select of the far slave
  logic clock_polarity_sel = 1'b0;
  logic clock_phase_sel = 1'b0;
  logic [7:0] ptx = 8'h00; // far slave outgoing byte
  logic [7:0] prx; // far slave received byte
  logic peer_miso;
  logic rx_err_irq_o;
  spixf_pins_t pins;
  logic [7:0] q; // last read data
  logic [31:0] seed = 32'h2C522B14;
  int err_total = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  int lat;
  int div;
  logic [7:0] exp_q[$]; // model of the receive register
  // wire levels: released lines fall back to idle or bench data
  wire sck_w = pins.sck_oe ? pins.sck : clock_polarity_sel;
  wire mosi_w = pins.mosi_oe ? pins.mosi : ptx[0];
  wire miso_w = pins.miso_oe ? pins.miso : peer_miso;

  always #20 clk_i = ~clk_i;

  spixf_core i_spixf_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(dut_ss_n), .pins_o(pins),
    .rx_err_irq_o(rx_err_irq_o));
  spixf_peer i_spixf_peer (.sck_i(sck_w), .mosi_i(mosi_w), .ss_n_i(peer_ss_n),
    .miso_o(peer_miso), .clock_polarity_sel_i(clock_polarity_sel), .clock_phase_sel_i(clock_phase_sel), .tx_i(ptx), .rx_o(prx));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask

  // one classic cycle; hold until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    chk({7'h0, ack_o}, 8'h01);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (rx_err_irq_o !== 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    chk({7'h0, rx_err_irq_o}, 8'h01);
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the longest sequence
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      err_total++;
      $display("ERROR %0t run timed out", $time);
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    chk({5'h0, pins.sck_oe, pins.mosi_oe, pins.miso_oe}, 8'h00);
    rst_i <= 1'b0;
    wb(1'b0, SPIXF_OFF_CTRL, 8'h00);
    chk(q, 8'h28);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h08);
    wb(1'b0, 4'hC, 8'h00);
    chk(q, 8'h00);
    // master: every phase, polarity and rate
    for (int i = 0; i < 16; i++) begin
      clock_phase_sel <= i[0];
      clock_polarity_sel <= i[1];
      wb(1'b1, SPIXF_OFF_CTRL, 8'h20);
      wb(1'b1, SPIXF_OFF_CTRL, {3'b101, i[1], i[0], 3'b010});
      wb(1'b1, SPIXF_OFF_STAT, {6'h00, i[3:2]});
      seed = lfsr(seed);
      ptx <= seed[7:0];
      exp_q.push_back(seed[7:0]);
      @(posedge clk_i);
      peer_ss_n <= 1'b0;
      wb(1'b1, SPIXF_OFF_DATA, seed[15:8]);
      chk({7'h0, sck_w}, {7'h0, clock_polarity_sel});
      lat = 0;
      while (sck_w === clock_polarity_sel && lat < 400) begin
        @(posedge clk_i);
        lat++;
      end
      div = 2 << (2 * i[3:2]);
      chk({7'h0, lat <= div + div / 2 + 6}, 8'h01);
      wait_irq();
      wb(1'b0, SPIXF_OFF_STAT, 8'h00);
      chk(q, {6'h22, i[3:2]});
      wb(1'b0, SPIXF_OFF_DATA, 8'h00);
      chk(q, exp_q.pop_front());
      chk(prx, seed[15:8]);
      peer_ss_n <= 1'b1;
    end
    // overflow: second byte lands on unread data
    clock_polarity_sel <= 1'b0;
    clock_phase_sel <= 1'b1;
    wb(1'b1, SPIXF_OFF_CTRL, 8'hAA);
    wb(1'b1, SPIXF_OFF_STAT, 8'h40);
    for (int j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      ptx <= seed[7:0];
      if (j == 0) exp_q.push_back(seed[7:0]);
      @(posedge clk_i);
      peer_ss_n <= 1'b0;
      wb(1'b1, SPIXF_OFF_DATA, seed[15:8]);
      wait_irq();
      wb(1'b1, SPIXF_OFF_CTRL, 8'h2A);
      peer_ss_n <= 1'b1;
    end
    repeat (20) @(posedge clk_i);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'hE8);
    wb(1'b0, SPIXF_OFF_DATA, 8'h00);
    chk(q, exp_q.pop_front());
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h48);
    // master fault on select low
    wb(1'b1, SPIXF_OFF_STAT, 8'h44);
    wb(1'b1, SPIXF_OFF_CTRL, 8'h22);
    dut_ss_n <= 1'b0;
    wait_irq();
    wb(1'b0, SPIXF_OFF_CTRL, 8'h00);
    chk(q, 8'h20);
    chk({5'h0, pins.sck_oe, pins.mosi_oe, pins.miso_oe}, 8'h00);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h5C);
    wb(1'b1, SPIXF_OFF_CTRL, 8'h22);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h5C);
    dut_ss_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    wb(1'b1, SPIXF_OFF_CTRL, 8'h20);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h4C);
    chk({7'h0, rx_err_irq_o}, 8'h00);
    // fault enable off: select low leaves everything alone
    wb(1'b1, SPIXF_OFF_STAT, 8'h40);
    wb(1'b1, SPIXF_OFF_CTRL, 8'h22);
    dut_ss_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h48);
    wb(1'b0, SPIXF_OFF_CTRL, 8'h00);
    chk(q, 8'h22);
    dut_ss_n <= 1'b1;
    // slave, phase 0: select drives the msb, deselect faults
    clock_polarity_sel <= 1'b0;
    wb(1'b1, SPIXF_OFF_CTRL, 8'h00);
    wb(1'b1, SPIXF_OFF_STAT, 8'h44);
    wb(1'b1, SPIXF_OFF_CTRL, 8'h02);
    seed = lfsr(seed);
    wb(1'b1, SPIXF_OFF_DATA, seed[7:0]);
    repeat (4) @(posedge clk_i);
    chk({7'h0, pins.miso_oe}, 8'h00);
    dut_ss_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({6'h0, pins.miso_oe, pins.miso}, {6'h0, 1'b1, seed[7]});
    dut_ss_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({7'h0, pins.miso_oe}, 8'h00);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h5C);
    wb(1'b1, SPIXF_OFF_CTRL, 8'h00);
    wb(1'b0, SPIXF_OFF_CTRL, 8'h00);
    chk(q, 8'h00);
    // slave, phase 1: select without clocks is no fault
    wb(1'b1, SPIXF_OFF_CTRL, 8'h08);
    wb(1'b1, SPIXF_OFF_CTRL, 8'h0A);
    dut_ss_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    dut_ss_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    wb(1'b0, SPIXF_OFF_STAT, 8'h00);
    chk(q, 8'h4C);
    tally_and_finish();
  end
endmodule
